/* psr_map.svh */
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PSR_SYSCTL_BASE 32'h400fe000
`define PSR_OFS_CTRL_0 12'h040
`define PSR_OFS_CTRL_1 12'h044
`define PSR_OFS_STATUS 12'h050
`define PSR_OFS_CAP_A 12'h054
`define PSR_OFS_CAP_B 12'h058

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PSR_CTRL_0_RESET 32'h00000000
`define PSR_CTRL_1_RESET 32'h00000000
`define PSR_CTRL_0_MASK 32'h00010048
`define PSR_CTRL_1_MASK 32'h01071013

// ----------------------------------------------------------------
// Field positions, first register
// ----------------------------------------------------------------
`define PSR_BIT_CONVERTER 16
`define PSR_BIT_HIBERNATE 6
`define PSR_BIT_WATCHDOG 3

// ----------------------------------------------------------------
// Field positions, second register
// ----------------------------------------------------------------
`define PSR_BIT_COMPARATOR 24
`define PSR_BIT_COUNTER_C 18
`define PSR_BIT_COUNTER_B 17
`define PSR_BIT_COUNTER_A 16
`define PSR_BIT_TWO_WIRE 12
`define PSR_BIT_SYNC_SERIAL 4
`define PSR_BIT_ASYNC_B 1
`define PSR_BIT_ASYNC_A 0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PSR_BIT_WR_BLOCKED 0
`define PSR_BIT_ANY_RESET 1

`endif

/* psr_pkg.sv */
package psr_pkg;

   // ----------------------------------------------------------------
   // Bus types
   // ----------------------------------------------------------------
   typedef logic [11:0] psr_addr_t;
   typedef logic [31:0] psr_data_t;
   typedef logic [3:0] psr_strb_t;

   // Register selected by the current address
   typedef enum logic [2:0] {
      PSR_SEL_NONE,
      PSR_SEL_CTRL_0,
      PSR_SEL_CTRL_1,
      PSR_SEL_STATUS,
      PSR_SEL_CAP_A,
      PSR_SEL_CAP_B
   } psr_sel_t;

endpackage : psr_pkg

/* psr_gated_reg.sv */
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_gated_reg #(
   parameter int WIDTH = 32,
   parameter logic [WIDTH-1:0] DEFINED_MASK = '0,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Write request
   input wire logic wr_en_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   input wire logic [WIDTH-1:0] lane_mask_i,
   // Units present in this device
   input wire logic [WIDTH-1:0] cap_i,
   // Register state
   output logic [WIDTH-1:0] q_o,
   output logic blocked_o
);

   // ----------------------------------------------------------------
   // Write gating
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] wr_mask;
   logic [WIDTH-1:0] next_q;

   // Only defined, present bits in enabled byte lanes may change
   assign wr_mask = DEFINED_MASK & cap_i & lane_mask_i;
   assign next_q = (q_o & ~wr_mask) | (wr_data_i & wr_mask);

   // Bits stay set until software clears them
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_o <= RESET_VALUE;
      end else if (wr_en_i) begin
         q_o <= next_q;
      end
   end

   // Flag a write that tried to set a bit of an absent unit
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blocked_o <= 1'b0;
      end else begin
         blocked_o <= wr_en_i &
            (|(wr_data_i & lane_mask_i & DEFINED_MASK & ~cap_i));
      end
   end

endmodule : psr_gated_reg

/* psr_reset_ctrl.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_reset_ctrl (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire psr_pkg::psr_addr_t PADDR_I,
   input wire psr_pkg::psr_data_t PWDATA_I,
   input wire psr_pkg::psr_strb_t PSTRB_I,
   output psr_pkg::psr_data_t PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Units present, from the capability registers
   input wire psr_pkg::psr_data_t CAPABILITY_MASK_A_I,
   input wire psr_pkg::psr_data_t CAPABILITY_MASK_B_I,
   // Resets from the first register, active high
   output logic CONVERTER_UNIT_RESET_O,
   output logic HIBERNATE_UNIT_RESET_O,
   output logic WATCHDOG_UNIT_RESET_O,
   // Resets from the second register, active high
   output logic COMPARATOR_UNIT_RESET_O,
   output logic GP_COUNTER_C_RESET_O,
   output logic GP_COUNTER_B_RESET_O,
   output logic GP_COUNTER_A_RESET_O,
   output logic TWO_WIRE_UNIT_RESET_O,
   output logic SYNC_SERIAL_UNIT_RESET_O,
   output logic ASYNC_SERIAL_B_RESET_O,
   output logic ASYNC_SERIAL_A_RESET_O
);

   import psr_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Address decode, shared by read and write paths
   function automatic psr_sel_t decode_addr(input psr_addr_t addr);
      psr_sel_t sel;
      sel = PSR_SEL_NONE;
      unique case (addr)
         `PSR_OFS_CTRL_0: sel = PSR_SEL_CTRL_0;
         `PSR_OFS_CTRL_1: sel = PSR_SEL_CTRL_1;
         `PSR_OFS_STATUS: sel = PSR_SEL_STATUS;
         `PSR_OFS_CAP_A: sel = PSR_SEL_CAP_A;
         `PSR_OFS_CAP_B: sel = PSR_SEL_CAP_B;
         default: sel = PSR_SEL_NONE;
      endcase
      return sel;
   endfunction : decode_addr

   // Byte strobes widened to a bit mask
   function automatic psr_data_t lane_mask(input psr_strb_t strb);
      psr_data_t m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction : lane_mask

   // ----------------------------------------------------------------
   // Bus phase decode
   // ----------------------------------------------------------------
   psr_sel_t sel;
   logic setup_phase;
   logic access_done;
   logic wr_done;
   psr_data_t wr_lanes;

   assign sel = decode_addr(PADDR_I);
   assign setup_phase = PSEL_I & ~PENABLE_I;
   // Transfer completes on the access edge that sees pready high
   assign access_done = PSEL_I & PENABLE_I & PREADY_O;
   assign wr_done = access_done & PWRITE_I;
   assign wr_lanes = lane_mask(PSTRB_I);

   // ----------------------------------------------------------------
   // Reset control registers
   // ----------------------------------------------------------------
   psr_data_t ctrl_0;
   psr_data_t ctrl_1;
   logic blocked_0;
   logic blocked_1;
   logic wr_ctrl_0;
   logic wr_ctrl_1;

   assign wr_ctrl_0 = wr_done & (sel == PSR_SEL_CTRL_0);
   assign wr_ctrl_1 = wr_done & (sel == PSR_SEL_CTRL_1);

   // First register, gated by capability mask A
   psr_gated_reg #(
      .WIDTH(32),
      .DEFINED_MASK(`PSR_CTRL_0_MASK),
      .RESET_VALUE(`PSR_CTRL_0_RESET)
   ) u_ctrl_0 (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESET_N_I),
      .wr_en_i(wr_ctrl_0),
      .wr_data_i(PWDATA_I),
      .lane_mask_i(wr_lanes),
      .cap_i(CAPABILITY_MASK_A_I),
      .q_o(ctrl_0),
      .blocked_o(blocked_0)
   );

   // Second register, gated by capability mask B
   psr_gated_reg #(
      .WIDTH(32),
      .DEFINED_MASK(`PSR_CTRL_1_MASK),
      .RESET_VALUE(`PSR_CTRL_1_RESET)
   ) u_ctrl_1 (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESET_N_I),
      .wr_en_i(wr_ctrl_1),
      .wr_data_i(PWDATA_I),
      .lane_mask_i(wr_lanes),
      .cap_i(CAPABILITY_MASK_B_I),
      .q_o(ctrl_1),
      .blocked_o(blocked_1)
   );

   // ----------------------------------------------------------------
   // Peripheral reset outputs
   // ----------------------------------------------------------------

   // Straight from the register flops, so no added latency
   assign CONVERTER_UNIT_RESET_O = ctrl_0[`PSR_BIT_CONVERTER];
   assign HIBERNATE_UNIT_RESET_O = ctrl_0[`PSR_BIT_HIBERNATE];
   assign WATCHDOG_UNIT_RESET_O = ctrl_0[`PSR_BIT_WATCHDOG];

   // Second register group
   assign COMPARATOR_UNIT_RESET_O = ctrl_1[`PSR_BIT_COMPARATOR];
   assign GP_COUNTER_C_RESET_O = ctrl_1[`PSR_BIT_COUNTER_C];
   assign GP_COUNTER_B_RESET_O = ctrl_1[`PSR_BIT_COUNTER_B];
   assign GP_COUNTER_A_RESET_O = ctrl_1[`PSR_BIT_COUNTER_A];
   assign TWO_WIRE_UNIT_RESET_O = ctrl_1[`PSR_BIT_TWO_WIRE];
   assign SYNC_SERIAL_UNIT_RESET_O = ctrl_1[`PSR_BIT_SYNC_SERIAL];
   assign ASYNC_SERIAL_B_RESET_O = ctrl_1[`PSR_BIT_ASYNC_B];
   assign ASYNC_SERIAL_A_RESET_O = ctrl_1[`PSR_BIT_ASYNC_A];

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   logic wr_blocked;
   logic any_reset;
   logic clr_blocked;

   // Write one to clear; a new event in the same cycle wins
   assign clr_blocked = wr_done & (sel == PSR_SEL_STATUS) &
      PSTRB_I[0] & PWDATA_I[`PSR_BIT_WR_BLOCKED];

   // Sticky record of a write refused for an absent unit
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wr_blocked <= 1'b0;
      end else if (blocked_0 | blocked_1) begin
         wr_blocked <= 1'b1;
      end else if (clr_blocked) begin
         wr_blocked <= 1'b0;
      end
   end

   // Live summary: some peripheral is held in reset now
   assign any_reset = (|ctrl_0) | (|ctrl_1);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   psr_data_t rd_value;
   logic rd_error;

   // Reserved bits come out as zero, the register holds none
   always_comb begin
      rd_value = '0;
      rd_error = 1'b0;
      unique case (sel)
         PSR_SEL_CTRL_0: rd_value = ctrl_0 & `PSR_CTRL_0_MASK;
         PSR_SEL_CTRL_1: rd_value = ctrl_1 & `PSR_CTRL_1_MASK;
         PSR_SEL_STATUS: begin
            rd_value[`PSR_BIT_WR_BLOCKED] = wr_blocked;
            rd_value[`PSR_BIT_ANY_RESET] = any_reset;
         end
         PSR_SEL_CAP_A: rd_value = CAPABILITY_MASK_A_I;
         PSR_SEL_CAP_B: rd_value = CAPABILITY_MASK_B_I;
         PSR_SEL_NONE: rd_error = 1'b1;
      endcase
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------

   // One wait-free access phase: ready follows every setup cycle
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         PREADY_O <= 1'b0;
      end else begin
         PREADY_O <= setup_phase;
      end
   end

   // Data and error captured in setup, held through access
   always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         PRDATA_O <= '0;
         PSLVERR_O <= 1'b0;
      end else if (setup_phase) begin
         PRDATA_O <= PWRITE_I ? '0 : rd_value;
         PSLVERR_O <= rd_error;
      end else if (access_done) begin
         PRDATA_O <= '0;
         PSLVERR_O <= 1'b0;
      end
   end

endmodule : psr_reset_ctrl

/* psr_reset_ctrl_props.sv */
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_reset_ctrl_props (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // APB side
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire psr_pkg::psr_addr_t PADDR_I,
   input wire psr_pkg::psr_data_t PWDATA_I,
   input wire psr_pkg::psr_strb_t PSTRB_I,
   input wire psr_pkg::psr_data_t PRDATA_O,
   input wire logic PREADY_O,
   // Capabilities and watched reset lines
   input wire psr_pkg::psr_data_t CAPABILITY_MASK_A_I,
   input wire psr_pkg::psr_data_t CAPABILITY_MASK_B_I,
   input wire logic CONVERTER_UNIT_RESET_O,
   input wire logic WATCHDOG_UNIT_RESET_O,
   input wire logic COMPARATOR_UNIT_RESET_O,
   input wire logic GP_COUNTER_A_RESET_O,
   input wire logic ASYNC_SERIAL_B_RESET_O
);
   import psr_pkg::*;
   // ----------------------------------------
   // Register writes and reset lines
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   // Completed write access to one offset
   sequence wr_s(ofs);
      PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == ofs;
   endsequence
   // Present unit on an enabled lane: line follows the written bit
   property wr0_p(o, int b);
      wr_s(`PSR_OFS_CTRL_0) ##0 (CAPABILITY_MASK_A_I[b] && PSTRB_I[b/8])
         |=> o == $past(PWDATA_I[b]);
   endproperty
   property wr1_p(o, int b);
      wr_s(`PSR_OFS_CTRL_1) ##0 (CAPABILITY_MASK_B_I[b] && PSTRB_I[b/8])
         |=> o == $past(PWDATA_I[b]);
   endproperty

   ready_pulse_a: assert property (
      PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
      else $error("ready pulse wrong");
   conv_wr_a: assert property (wr0_p(CONVERTER_UNIT_RESET_O, 16))
      else $error("converter line wrong");
   wdog_wr_a: assert property (wr0_p(WATCHDOG_UNIT_RESET_O, 3))
      else $error("watchdog line wrong");
   comp_wr_a: assert property (wr1_p(COMPARATOR_UNIT_RESET_O, 24))
      else $error("comparator line wrong");
   counter_wr_a: assert property (wr1_p(GP_COUNTER_A_RESET_O, 16))
      else $error("counter line wrong");
   async_wr_a: assert property (wr1_p(ASYNC_SERIAL_B_RESET_O, 1))
      else $error("async serial line wrong");
   conv_gated_a: assert property (
      wr_s(`PSR_OFS_CTRL_0) ##0 !CAPABILITY_MASK_A_I[16]
         |=> $stable(CONVERTER_UNIT_RESET_O))
      else $error("absent unit bit changed");
   reserved_zero_a: assert property (
      PREADY_O && !PWRITE_I && PADDR_I == `PSR_OFS_CTRL_1
         |-> (PRDATA_O & ~`PSR_CTRL_1_MASK) == '0)
      else $error("reserved bits not zero");
   // The watchdog reset line may only move right after a write to the first register
   wdog_hold_a: assert property (
      $changed(WATCHDOG_UNIT_RESET_O) |-> $past(PSEL_I && PENABLE_I
         && PREADY_O && PWRITE_I && PADDR_I == `PSR_OFS_CTRL_0))
      else $error("watchdog line moved without write");
endmodule : psr_reset_ctrl_props

/* psr_reset_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "psr_map.svh"

module psr_reset_ctrl_tb_top;
   import psr_pkg::*;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic ref_clk = 1'b0, reset_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   psr_addr_t paddr = '0;
   psr_strb_t pstrb = '0;
   psr_data_t pwdata = '0, cap_a = '1, cap_b = '1, prdata, rdv;
   logic pready, pslverr, errv;
   wire [10:0] rst_v;
   int failures = 0, cmp_count = 0;

   psr_reset_ctrl dut (
      .REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr),
      .CAPABILITY_MASK_A_I(cap_a), .CAPABILITY_MASK_B_I(cap_b),
      .CONVERTER_UNIT_RESET_O(rst_v[10]), .HIBERNATE_UNIT_RESET_O(rst_v[9]),
      .WATCHDOG_UNIT_RESET_O(rst_v[8]), .COMPARATOR_UNIT_RESET_O(rst_v[7]),
      .GP_COUNTER_C_RESET_O(rst_v[6]), .GP_COUNTER_B_RESET_O(rst_v[5]),
      .GP_COUNTER_A_RESET_O(rst_v[4]), .TWO_WIRE_UNIT_RESET_O(rst_v[3]),
      .SYNC_SERIAL_UNIT_RESET_O(rst_v[2]), .ASYNC_SERIAL_B_RESET_O(rst_v[1]),
      .ASYNC_SERIAL_A_RESET_O(rst_v[0])
   );

   // 4 ns period
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string name, input psr_data_t seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input psr_addr_t a, input psr_data_t d,
         input psr_strb_t s);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= wr ? s : 4'h0;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // A slave that never answers ends the run as a mismatch
      if (pready !== 1'b1) begin
         failures++;
         end_of_test();
      end else begin
         rdv = prdata;
         errv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   // Reads both registers; reset lines must mirror them
   task automatic chk_regs(input psr_data_t e0, e1);
      apb(1'b0, `PSR_OFS_CTRL_0, '0, '0);
      check("ctrl_0", rdv, e0);
      apb(1'b0, `PSR_OFS_CTRL_1, '0, '0);
      check("ctrl_1", rdv, e1);
      check("reset_lines", {21'h0, rst_v}, {21'h0, e0[16], e0[6], e0[3],
         e1[24], e1[18], e1[17], e1[16], e1[12], e1[4], e1[1], e1[0]});
   endtask : chk_regs

   task automatic do_reset();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
   endtask : do_reset

   task automatic t_first_reg();
      chk_regs(32'h0, 32'h0);
      apb(1'b1, `PSR_OFS_CTRL_0, 32'hffffffff, 4'hf);
      chk_regs(32'h00010048, 32'h0);
      apb(1'b1, `PSR_OFS_CTRL_0, 32'h0, 4'hf);
      chk_regs(32'h0, 32'h0);
   endtask : t_first_reg

   task automatic t_second_reg();
      apb(1'b1, `PSR_OFS_CTRL_1, 32'hffffffff, 4'hf);
      chk_regs(32'h0, 32'h01071013);
      // Lane 0 only: the upper units must stay in reset
      apb(1'b1, `PSR_OFS_CTRL_1, 32'h0, 4'h1);
      chk_regs(32'h0, 32'h01071000);
      apb(1'b1, `PSR_OFS_CTRL_1, 32'h0, 4'hf);
   endtask : t_second_reg

   task automatic t_rmw_unmapped();
      apb(1'b0, 12'h048, '0, '0);
      check("unmapped_err", {31'h0, errv}, 32'h1);
      check("unmapped_data", rdv, 32'h0);
      // Read-modify-write writes reserved bits back as read
      apb(1'b0, `PSR_OFS_CTRL_1, '0, '0);
      apb(1'b1, `PSR_OFS_CTRL_1, rdv | 32'h00000002, 4'hf);
      chk_regs(32'h0, 32'h00000002);
   endtask : t_rmw_unmapped

   task automatic t_cap_gate();
      @(posedge ref_clk);
      cap_a <= 32'h00000008;
      cap_b <= 32'h00001000;
      apb(1'b1, `PSR_OFS_CTRL_0, 32'hffffffff, 4'hf);
      apb(1'b1, `PSR_OFS_CTRL_1, 32'hffffffff, 4'hf);
      chk_regs(32'h00000008, 32'h00001002);
      // Refused bits leave a sticky mark; writing one clears it
      apb(1'b0, `PSR_OFS_STATUS, '0, '0);
      check("status_set", rdv, 32'h3);
      check("status_err", {31'h0, errv}, 32'h0);
      apb(1'b1, `PSR_OFS_STATUS, 32'h1, 4'h1);
      apb(1'b0, `PSR_OFS_STATUS, '0, '0);
      check("status_clr", rdv, 32'h2);
      apb(1'b0, `PSR_OFS_CAP_A, '0, '0);
      check("cap_a_read", rdv, 32'h00000008);
      apb(1'b0, `PSR_OFS_CAP_B, '0, '0);
      check("cap_b_read", rdv, 32'h00001000);
      // Mid-run reset clears everything
      do_reset();
      chk_regs(32'h0, 32'h0);
      apb(1'b0, `PSR_OFS_STATUS, '0, '0);
      check("status_rst", rdv, 32'h0);
   endtask : t_cap_gate

   initial begin
      do_reset();
      t_first_reg();
      t_second_reg();
      t_rmw_unmapped();
      t_cap_gate();
      end_of_test();
   end
endmodule : psr_reset_ctrl_tb_top

bind psr_reset_ctrl psr_reset_ctrl_props chk (.REF_CLK_I, .RESET_N_I,
   .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PSTRB_I,
   .PRDATA_O, .PREADY_O, .CAPABILITY_MASK_A_I, .CAPABILITY_MASK_B_I,
   .CONVERTER_UNIT_RESET_O, .WATCHDOG_UNIT_RESET_O, .COMPARATOR_UNIT_RESET_O,
   .GP_COUNTER_A_RESET_O, .ASYNC_SERIAL_B_RESET_O);
